// ===== pkg/spi_port_pkg.sv
// shared types and constants of the serial peripheral port
package spi_port_pkg;
	localparam int          BITS_PER_BYTE   = 8;
	localparam int          HALF_EDGES      = 2 * BITS_PER_BYTE;
	localparam int          SCK_HALF_CYCLES = 4;
	localparam int          NSS_SETUP_CLKS  = 2;
	localparam logic [7:0]  TX_RESET        = 8'h00;
	localparam logic [7:0]  RX_RESET        = 8'h00;
	localparam logic [1:0]  SEL_MODE_RESET  = 2'h1;
	localparam logic [2:0]  CNT_LAST        = 3'h7;

	typedef enum logic [1:0] {
		SEL_THREE_WIRE = 2'b00,
		SEL_FOUR_WIRE  = 2'b01,
		SEL_OUT_LOW    = 2'b10,
		SEL_OUT_HIGH   = 2'b11
	} sel_mode_t;

	typedef enum logic {
		ST_IDLE  = 1'b0,
		ST_SHIFT = 1'b1
	} xfer_state_t;

	typedef struct packed {
		logic      master_enable_bit;
		logic      port_enable_bit;
		sel_mode_t select_pin_mode_field;
		logic      clock_polarity_bit;
		logic      clock_phase_bit;
	} ctrl_t;

	typedef struct packed {
		logic transfer_done_flag;
		logic write_collision_flag;
		logic mode_fault_flag;
		logic receive_overrun_flag;
	} flags_t;

	typedef struct packed {
		logic busy;
		logic selected;
		logic nss_level;
		logic shift_empty;
		logic rx_empty;
	} status_t;
endpackage

// ===== src/level_sync.sv
// two flip-flop synchroniser for pin levels
module level_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk_sys_in,
	input  wire logic             rstn_in,
	input  wire logic [WIDTH-1:0] d_in,
	output logic      [WIDTH-1:0] q_out
);
	logic [WIDTH-1:0] stage;

	always_ff @(posedge clk_sys_in) begin
		if (!rstn_in) begin
			stage <= '0;
			q_out <= '0;
		end else begin
			stage <= d_in;
			q_out <= stage;
		end
	end
endmodule // level_sync

// ===== src/sck_tick_gen.sv
// half-period tick source for the master serial clock
module sck_tick_gen #(
	parameter int HALF_CYCLES = 4
) (
	input  wire logic clk_sys_in,
	input  wire logic rstn_in,
	input  wire logic run_in,
	output logic      tick_out
);
	localparam logic [7:0] LAST = 8'(HALF_CYCLES - 1);
	logic [7:0] count;

	// restarts on every run so the first half period is always whole
	always_ff @(posedge clk_sys_in) begin
		if (!rstn_in || !run_in) begin
			count    <= 8'h00;
			tick_out <= 1'b0;
		end else if (count == LAST) begin
			count    <= 8'h00;
			tick_out <= 1'b1;
		end else begin
			count    <= count + 8'h01;
			tick_out <= 1'b0;
		end
	end
endmodule // sck_tick_gen

// ===== src/serial_peripheral_port.sv
// serial peripheral port: master or slave, three or four wire
// Contract
// R1 - mosi driven from shift top as master
// R2 - miso floats when disabled or deselected
// R3 - three-wire slave always drives miso
// R4 - deselected four-wire slave ignores sck
// R5 - mode 00: three wire, slave always selected
// R6 - mode 01: nss input, select or fault
// R7 - mode 1x: nss output follows low bit
// R8 - master write loads buffer, starts transfer
// R9 - transfer done flag at byte end
// R10 - master receives msb first into buffer
// R11 - nss low clears enables, sets fault; done only on an nss fall, as master in mode 01
// R12 - select mode resets to 01
// R13 - enabled non-master acts as slave
// R14 - slave counts eight edges, sets done
// R15 - slave write goes through transmit buffer
// R16 - busy shifter reloads after last edge
// R17 - nss fall resets four-wire bit counter
// R18 - master holds nss low two clocks; not done, nss_out only follows select_pin_mode_field[0]
// R19 - three-wire counter reset only by disable
// R20 - write to full buffer sets collision
// R21 - slave overrun keeps old byte
// R22 - polarity and phase pick sck edges
// R23 - master idles sck, eight cycles per byte
module serial_peripheral_port
	import spi_port_pkg::*;
#(
	parameter int SCK_HALF = spi_port_pkg::SCK_HALF_CYCLES
) (
	input  wire logic                 clk_sys_in,
	input  wire logic                 rstn_in,
	input  wire logic                 ctrl_wr_in,
	input  wire spi_port_pkg::ctrl_t  ctrl_in,
	output spi_port_pkg::ctrl_t       ctrl_out,
	input  wire logic                 data_wr_in,
	input  wire logic [7:0]           data_wr_value_in,
	input  wire logic                 data_rd_in,
	output logic      [7:0]           data_rd_value_out,
	input  wire spi_port_pkg::flags_t flags_clear_in,
	output spi_port_pkg::flags_t      flags_out,
	output spi_port_pkg::status_t     status_out,
	input  wire logic                 sck_in,
	output logic                      sck_out,
	output logic                      sck_oe_n_out,
	input  wire logic                 mosi_in,
	output logic                      mosi_out,
	output logic                      mosi_oe_n_out,
	input  wire logic                 miso_in,
	output logic                      miso_out,
	output logic                      miso_oe_n_out,
	input  wire logic                 nss_in,
	output logic                      nss_out,
	output logic                      nss_oe_n_out
);
	import spi_port_pkg::*;

	ctrl_t       ctrl;
	flags_t      flags;
	xfer_state_t state;
	logic [3:0]  pins_s;
	logic        sck_s, mosi_s, miso_s, nss_s;
	logic        sck_prev, nss_prev;
	logic        master_on, slave_on, selected;
	logic        nss_fall, mode_fault;
	logic        tick, sck_act;
	logic [3:0]  half_cnt;
	logic [2:0]  bit_cnt;
	logic        lead_edge, trail_edge, sample_edge, shift_edge, byte_done;
	logic        din;
	logic [7:0]  tx_buf, shifter, rx_sh, rx_buf;
	logic [7:0]  next_rx;
	logic        tx_full, shift_full, rx_full, rx_eff_full;
	logic        write_ok, load_shift, start;

	// every pin input passes two flops before any logic reads it
	level_sync #(.WIDTH(4)) u_pin_sync (
		.clk_sys_in (clk_sys_in),
		.rstn_in    (rstn_in),
		.d_in       ({sck_in, mosi_in, miso_in, nss_in}),
		.q_out      (pins_s)
	);
	assign {sck_s, mosi_s, miso_s, nss_s} = pins_s;

	sck_tick_gen #(.HALF_CYCLES(SCK_HALF)) u_tick (
		.clk_sys_in (clk_sys_in),
		.rstn_in    (rstn_in),
		.run_in     (state == ST_SHIFT),
		.tick_out   (tick)
	);

	assign master_on = ctrl.port_enable_bit & ctrl.master_enable_bit;
	assign slave_on  = ctrl.port_enable_bit & !ctrl.master_enable_bit; // R13

	// selection as seen by the slave side
	always_comb begin
		case (ctrl.select_pin_mode_field)
			SEL_THREE_WIRE: selected = 1'b1;    // R5
			SEL_FOUR_WIRE:  selected = !nss_s;  // R6 R17
			default:        selected = 1'b0;
		endcase
	end

	assign nss_fall   = nss_prev & !nss_s;
	assign mode_fault = master_on & nss_fall
		& (ctrl.select_pin_mode_field == SEL_FOUR_WIRE); // R6 R11

	always_ff @(posedge clk_sys_in) begin
		if (!rstn_in) begin
			sck_prev <= 1'b0;
			nss_prev <= 1'b0; // matches the synchroniser reset, so no false fall
		end else begin
			sck_prev <= sck_s ^ ctrl.clock_polarity_bit;
			nss_prev <= nss_s;
		end
	end

	// control bits: the fault wins over a software write in the same cycle
	always_ff @(posedge clk_sys_in) begin
		if (!rstn_in) begin
			ctrl.master_enable_bit     <= 1'b0;
			ctrl.port_enable_bit       <= 1'b0;
			ctrl.select_pin_mode_field <= sel_mode_t'(SEL_MODE_RESET); // R12
			ctrl.clock_polarity_bit    <= 1'b0;
			ctrl.clock_phase_bit       <= 1'b0;
		end else begin
			if (ctrl_wr_in) begin
				ctrl <= ctrl_in;
			end
			if (mode_fault) begin
				ctrl.master_enable_bit <= 1'b0; // R11
				ctrl.port_enable_bit   <= 1'b0; // R11
			end
		end
	end

	// master clock generation: idle level between bytes, sixteen half periods
	always_ff @(posedge clk_sys_in) begin
		if (!rstn_in) begin
			state    <= ST_IDLE;
			sck_act  <= 1'b0;
			half_cnt <= 4'h0;
		end else if (!master_on || mode_fault) begin
			state    <= ST_IDLE;
			sck_act  <= 1'b0;
			half_cnt <= 4'h0;
		end else begin
			case (state)
				ST_IDLE: begin
					sck_act  <= 1'b0; // R23
					half_cnt <= 4'h0;
					if (start) begin
						state <= ST_SHIFT; // R8
					end
				end
				ST_SHIFT: begin
					if (tick) begin
						sck_act  <= !sck_act;
						half_cnt <= half_cnt + 4'h1;
						if (half_cnt == 4'(HALF_EDGES - 1)) begin
							state <= ST_IDLE; // R23
						end
					end
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	assign start = (state == ST_IDLE) & master_on & shift_full;

	// edges, master or slave; a deselected slave sees none
	always_comb begin
		if (master_on) begin
			lead_edge  = (state == ST_SHIFT) & tick & !sck_act;
			trail_edge = (state == ST_SHIFT) & tick & sck_act;
			din        = miso_s; // R10
		end else begin
			lead_edge  = slave_on & selected & (sck_s ^ ctrl.clock_polarity_bit)
				& !sck_prev; // R4 R22
			trail_edge = slave_on & selected & !(sck_s ^ ctrl.clock_polarity_bit)
				& sck_prev; // R4 R22
			din        = mosi_s;
		end
	end

	assign sample_edge = ctrl.clock_phase_bit ? trail_edge : lead_edge; // R22
	assign shift_edge  = ctrl.clock_phase_bit ? lead_edge : trail_edge; // R22
	assign byte_done   = sample_edge & (bit_cnt == CNT_LAST);
	assign next_rx     = {rx_sh[6:0], din};

	// bit counter: in three-wire slave mode only a disable clears it
	always_ff @(posedge clk_sys_in) begin
		if (!rstn_in || !ctrl.port_enable_bit) begin
			bit_cnt <= 3'h0; // R19
		end else if (start) begin
			bit_cnt <= 3'h0;
		end else if (slave_on && nss_fall
			&& ctrl.select_pin_mode_field == SEL_FOUR_WIRE) begin
			bit_cnt <= 3'h0; // R17
		end else if (sample_edge) begin
			bit_cnt <= bit_cnt + 3'h1; // R14
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (!rstn_in) begin
			rx_sh <= RX_RESET;
		end else if (sample_edge) begin
			rx_sh <= next_rx; // R10
		end
	end

	// transmit path: buffer then shifter; the shifter holds its msb first
	assign write_ok   = data_wr_in & !tx_full;
	assign load_shift = tx_full & (!shift_full | byte_done);

	always_ff @(posedge clk_sys_in) begin
		if (!rstn_in) begin
			tx_buf  <= TX_RESET;
			tx_full <= 1'b0;
		end else if (write_ok) begin
			tx_buf  <= data_wr_value_in; // R8 R15
			tx_full <= 1'b1;
		end else if (load_shift) begin
			tx_full <= 1'b0;
		end
	end

	// a byte that arrives mid-transfer waits for the last edge
	always_ff @(posedge clk_sys_in) begin
		if (!rstn_in) begin
			shifter    <= TX_RESET;
			shift_full <= 1'b0;
		end else if (load_shift) begin
			shifter    <= tx_buf; // R15 R16
			shift_full <= 1'b1;
		end else if (byte_done) begin
			shift_full <= 1'b0;
		end else if (shift_edge && bit_cnt != 3'h0) begin
			shifter <= {shifter[6:0], 1'b0}; // R1
		end
	end

	// a read in the same cycle as the byte end counts as already done
	assign rx_eff_full = rx_full & !data_rd_in;

	always_ff @(posedge clk_sys_in) begin
		if (!rstn_in) begin
			rx_buf  <= RX_RESET;
			rx_full <= 1'b0;
		end else if (byte_done && !(slave_on && rx_eff_full)) begin
			rx_buf  <= next_rx; // R10 R14
			rx_full <= 1'b1;
		end else if (data_rd_in) begin
			rx_full <= 1'b0;
		end
	end

	// sticky flags: a set wins over a clear in the same cycle
	always_ff @(posedge clk_sys_in) begin
		if (!rstn_in) begin
			flags <= '0;
		end else begin
			flags <= flags & ~flags_clear_in;
			if (byte_done) begin
				flags.transfer_done_flag <= 1'b1; // R9 R14
			end
			if (data_wr_in && tx_full) begin
				flags.write_collision_flag <= 1'b1; // R20
			end
			if (mode_fault) begin
				flags.mode_fault_flag <= 1'b1; // R11
			end
			if (byte_done && slave_on && rx_eff_full) begin
				flags.receive_overrun_flag <= 1'b1; // R21
			end
		end
	end

	// pins: enable low means this end drives
	assign mosi_out      = shifter[7]; // R1
	assign mosi_oe_n_out = !master_on; // R1
	assign miso_out      = shifter[7]; // R3
	assign miso_oe_n_out = !(slave_on & selected); // R2 R3
	assign sck_out       = sck_act ^ ctrl.clock_polarity_bit; // R23
	assign sck_oe_n_out  = !master_on;
	assign nss_out       = ctrl.select_pin_mode_field[0]; // R7
	assign nss_oe_n_out  = !(ctrl.port_enable_bit & ctrl.select_pin_mode_field[1]); // R7

	assign ctrl_out          = ctrl;
	assign flags_out         = flags;
	assign data_rd_value_out = rx_buf;
	assign status_out        = '{busy: (state == ST_SHIFT) | (slave_on & bit_cnt != 3'h0),
		selected: slave_on & selected, nss_level: nss_s,
		shift_empty: !shift_full, rx_empty: !rx_full};

	// helper: counts leading edges of each master byte
	logic [3:0] lead_seen;
	always_ff @(posedge clk_sys_in) begin
		if (!rstn_in || start) begin
			lead_seen <= 4'h0;
		end else if (master_on && lead_edge) begin
			lead_seen <= lead_seen + 4'h1;
		end
	end

	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!rstn_in);

	sequence s_write_taken;
		data_wr_in && !tx_full && !shift_full && !byte_done;
	endsequence
	sequence s_moved;
		tx_full && !shift_full ##1 shift_full && !tx_full;
	endsequence

	a_write_to_shift: assert property (s_write_taken |=> s_moved) // R8 R15
		else $error("written byte did not reach the shifter");
	a_collision_drop: assert property (data_wr_in && tx_full |=> // R20
		flags.write_collision_flag && tx_buf == $past(tx_buf))
		else $error("collision write was not discarded");
	a_mosi_master: assert property (master_on |-> !mosi_oe_n_out // R1
		&& mosi_out == shifter[7] && miso_oe_n_out)
		else $error("master mosi not driven from shifter");
	a_miso_float: assert property (!ctrl.port_enable_bit || (slave_on // R2
		&& ctrl.select_pin_mode_field == SEL_FOUR_WIRE && nss_s) |-> miso_oe_n_out)
		else $error("miso driven while it should float");
	a_miso_three: assert property (slave_on // R3 R5
		&& ctrl.select_pin_mode_field == SEL_THREE_WIRE |-> !miso_oe_n_out)
		else $error("three wire slave miso not driven");
	a_deselect_quiet: assert property (slave_on && nss_s // R4
		&& ctrl.select_pin_mode_field == SEL_FOUR_WIRE |=> $stable(bit_cnt))
		else $error("deselected slave counted sck");
	a_nss_output: assert property (ctrl.port_enable_bit // R7
		&& ctrl.select_pin_mode_field[1] |-> !nss_oe_n_out
		&& nss_out == ctrl.select_pin_mode_field[0])
		else $error("nss output level wrong");
	a_fault_clears: assert property (mode_fault |=> !ctrl.master_enable_bit // R11
		&& !ctrl.port_enable_bit && flags.mode_fault_flag && state == ST_IDLE)
		else $error("mode fault did not disable port");
	a_done_copies: assert property (byte_done && !(slave_on && rx_eff_full) // R9 R10 R14
		|=> flags.transfer_done_flag && rx_full && rx_buf == $past(next_rx))
		else $error("byte end did not copy or flag");
	a_overrun_keep: assert property (byte_done && slave_on && rx_eff_full // R21
		|=> flags.receive_overrun_flag && $stable(rx_buf))
		else $error("overrun lost the old byte");
	a_eight_cycles: assert property ($fell(state == ST_SHIFT) && master_on // R23
		|-> lead_seen == 4'h8 && sck_out == ctrl.clock_polarity_bit)
		else $error("master byte not eight sck cycles");
	a_master_done: assert property (start |-> ##[1:300] byte_done) // R9
		else $error("master transfer did not complete");
endmodule // serial_peripheral_port

// ===== tb/far_end.sv
// far end of the serial link: a slave that answers, or a master that drives
module far_end (
	input  wire logic sck_in,
	input  wire logic mosi_in,
	input  wire logic miso_in,
	output logic      sck_out,
	output logic      mosi_out,
	output logic      miso_out,
	output logic      nss_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic       slave_on = 1'b0;
	logic [7:0] slv_tx   = 8'h00;
	logic [7:0] slv_rx   = 8'h00;
	logic       pha      = 1'b0;
	initial begin
		sck_out = 1'b0;
		mosi_out = 1'b0;
		nss_out = 1'b1;
	end
	// a released line shows the inverse, so a stale bit never passes for data
	assign miso_out = slave_on ? slv_tx[7] : ~slv_tx[7];
	always @(posedge sck_in) if (slave_on) slv_rx <= {slv_rx[6:0], mosi_in};
	always @(negedge sck_in) if (slave_on) slv_tx <= {slv_tx[6:0], ~slv_tx[0]};
	task automatic load_slave(input logic [7:0] v);
		slv_tx = v;
		slave_on = 1'b1;
	endtask
	task automatic set_nss(input logic v);
		nss_out = v;
	endtask
	task automatic master_xfer(input logic [7:0] tx, input logic sel, output logic [7:0] rx);
		slave_on = 1'b0;
		nss_out = ~sel;
		#100;
		// phase 1 moves data on the rising edge and samples on the falling one
		for (int i = 7; i >= 0; i--) begin
			if (!pha) mosi_out = tx[i];
			#80 sck_out = 1'b1;
			if (pha) mosi_out = tx[i];
			else rx[i] = miso_in;
			#80 sck_out = 1'b0;
			if (pha) rx[i] = miso_in;
		end
		#100 nss_out = 1'b1;
		mosi_out = ~mosi_out;
	endtask
endmodule // far_end

// ===== tb/tb.sv
// self-checking bench of the serial peripheral port
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import spi_port_pkg::*;
	logic       clk_sys_in       = 1'b0;
	logic       rstn_in          = 1'b0;
	logic       ctrl_wr_in       = 1'b0;
	ctrl_t      ctrl_in          = '0;
	ctrl_t      ctrl_out;
	logic       data_wr_in       = 1'b0;
	logic [7:0] data_wr_value_in = 8'h00;
	logic       data_rd_in       = 1'b0;
	logic [7:0] data_rd_value_out;
	flags_t     flags_clear_in   = '0;
	flags_t     flags_out;
	status_t    status_out;
	logic       sck_out, sck_oe_n_out, mosi_out, mosi_oe_n_out;
	logic       miso_out, miso_oe_n_out, nss_out, nss_oe_n_out;
	logic       far_sck, far_mosi, far_miso, far_nss;
	logic       sck_in, mosi_in, miso_in, nss_in;
	logic [7:0] got;
	int         errors           = 0;
	int         comparisons      = 0;
	int         edges            = 0;
	assign sck_in  = sck_oe_n_out  ? far_sck  : sck_out;
	assign mosi_in = mosi_oe_n_out ? far_mosi : mosi_out;
	assign miso_in = miso_oe_n_out ? far_miso : miso_out;
	assign nss_in  = nss_oe_n_out  ? far_nss  : nss_out;
	always #10 clk_sys_in = ~clk_sys_in;
	always @(posedge sck_in) edges++;
	serial_peripheral_port #(.SCK_HALF(4)) uut (.clk_sys_in, .rstn_in, .ctrl_wr_in, .ctrl_in,
		.ctrl_out, .data_wr_in, .data_wr_value_in, .data_rd_in, .data_rd_value_out,
		.flags_clear_in, .flags_out, .status_out, .sck_in, .sck_out, .sck_oe_n_out, .mosi_in,
		.mosi_out, .mosi_oe_n_out, .miso_in, .miso_out, .miso_oe_n_out, .nss_in, .nss_out,
		.nss_oe_n_out);
	far_end far (.sck_in(sck_in), .mosi_in(mosi_in), .miso_in(miso_in), .sck_out(far_sck),
		.mosi_out(far_mosi), .miso_out(far_miso), .nss_out(far_nss));
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic summarize();
		$display("errors %0d comparisons %0d", errors, comparisons);
		if (errors == 0 && comparisons > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task automatic set_ctrl(input logic me, input logic pe, input logic [1:0] md, input logic cp,
		input logic ph = 1'b0);
		@(negedge clk_sys_in);
		ctrl_in = '{me, pe, sel_mode_t'(md), cp, ph};
		ctrl_wr_in = 1'b1;
		@(negedge clk_sys_in);
		ctrl_wr_in = 1'b0;
		repeat (4) @(negedge clk_sys_in);
	endtask
	// waits out the buffer-to-shifter move so the next write is not a collision
	task automatic wr_data(input logic [7:0] v);
		@(negedge clk_sys_in);
		data_wr_in = 1'b1;
		data_wr_value_in = v;
		@(negedge clk_sys_in);
		data_wr_in = 1'b0;
		repeat (4) @(negedge clk_sys_in);
	endtask
	task automatic rd_clear();
		@(negedge clk_sys_in);
		data_rd_in = 1'b1;
		flags_clear_in = flags_t'(4'hf);
		@(negedge clk_sys_in);
		data_rd_in = 1'b0;
		flags_clear_in = '0;
	endtask
	task automatic t_reset();
		check(ctrl_out.select_pin_mode_field, 16'h0001);
		check({sck_oe_n_out, mosi_oe_n_out, miso_oe_n_out, nss_oe_n_out}, 16'h000f);
		check(flags_out, 16'h0000);
	endtask
	task automatic t_master();
		far.load_slave(8'h3c);
		set_ctrl(1'b1, 1'b1, 2'h0, 1'b0);
		edges = 0;
		@(negedge clk_sys_in);
		data_wr_in = 1'b1;
		data_wr_value_in = 8'ha5;
		@(negedge clk_sys_in);
		data_wr_value_in = 8'h5a;
		@(negedge clk_sys_in);
		data_wr_in = 1'b0;
		for (int i = 0; i < 600 && flags_out.transfer_done_flag !== 1'b1; i++)
			@(negedge clk_sys_in);
		repeat (12) @(negedge clk_sys_in);
		check(flags_out, 16'h000c);
		check(far.slv_rx, 16'h00a5);
		check(data_rd_value_out, 16'h003c);
		check(16'(edges), 16'h0008);
		check({sck_in, status_out.busy}, 16'h0000);
		rd_clear();
		check(status_out.rx_empty, 16'h0001);
	endtask
	task automatic t_nss_out();
		set_ctrl(1'b1, 1'b1, 2'h2, 1'b1);
		check({nss_oe_n_out, nss_in, sck_in}, 16'h0001);
		set_ctrl(1'b1, 1'b1, 2'h3, 1'b1);
		check({nss_oe_n_out, nss_in}, 16'h0001);
	endtask
	task automatic t_fault();
		set_ctrl(1'b1, 1'b1, 2'h1, 1'b0);
		far.set_nss(1'b0);
		repeat (6) @(negedge clk_sys_in);
		check({ctrl_out.master_enable_bit, ctrl_out.port_enable_bit,
			flags_out.mode_fault_flag}, 16'h0001);
		far.set_nss(1'b1);
		rd_clear();
	endtask
	task automatic t_slave4();
		set_ctrl(1'b0, 1'b1, 2'h1, 1'b0);
		wr_data(8'h96);
		wr_data(8'h77);
		check(miso_oe_n_out, 16'h0001);
		check({status_out.selected, status_out.shift_empty, status_out.nss_level}, 16'h0001);
		far.master_xfer(8'h11, 1'b0, got);
		repeat (6) @(negedge clk_sys_in);
		check(flags_out.transfer_done_flag, 16'h0000);
		far.master_xfer(8'h5a, 1'b1, got);
		repeat (6) @(negedge clk_sys_in);
		check({got, data_rd_value_out}, 16'h965a);
		check(flags_out.transfer_done_flag, 16'h0001);
		far.master_xfer(8'he7, 1'b1, got);
		repeat (6) @(negedge clk_sys_in);
		check({got, data_rd_value_out}, 16'h775a);
		check(flags_out.receive_overrun_flag, 16'h0001);
	endtask
	task automatic t_slave3();
		rd_clear();
		set_ctrl(1'b0, 1'b0, 2'h0, 1'b0);
		set_ctrl(1'b0, 1'b1, 2'h0, 1'b0);
		wr_data(8'hc3);
		check(miso_oe_n_out, 16'h0000);
		far.master_xfer(8'h3e, 1'b0, got);
		repeat (6) @(negedge clk_sys_in);
		check({got, data_rd_value_out}, 16'hc33e);
		rd_clear();
		set_ctrl(1'b0, 1'b0, 2'h0, 1'b0, 1'b1);
		set_ctrl(1'b0, 1'b1, 2'h0, 1'b0, 1'b1);
		wr_data(8'h69);
		far.pha = 1'b1;
		far.master_xfer(8'hb4, 1'b0, got);
		repeat (6) @(negedge clk_sys_in);
		check({got, data_rd_value_out}, 16'h69b4);
	endtask
	initial begin
		repeat (6) @(negedge clk_sys_in);
		rstn_in = 1'b1;
		@(negedge clk_sys_in);
		t_reset();
		t_master();
		t_nss_out();
		t_fault();
		t_slave4();
		t_slave3();
		summarize();
	end
	// a full run needs about 12 us; the margin covers a stuck handshake
	initial begin
		#200000;
		errors++;
		summarize();
	end
endmodule // tb
